/* logic/dbm_mac_engine.sv */
`timescale 1ns/1ps
module dbm_mac_engine
   import dbm_pkg::*;
#(
   parameter int COMPUTE_BANK_CYCLES = DBM_COMPUTE_BANK_CYCLES
)
(
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   // i/o register port
   input wire logic [7:0] I_ADDR,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] I_WDATA,
   output logic [7:0] O_RDATA,
   // interrupt request
   output logic O_IRQ
);
   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   typedef struct packed
   {
      logic [1:0][7:0] ctl;       // per numbered bank control
      logic [1:0][39:0] acc;      // per numbered bank accumulator
      logic bank;                 // numbered bank holding data role
      logic data_ready;           // data bank holds defined calculation
      logic data_full;            // data bank holds a finished result
      dbm_compute_bank_e compute_bank;
      logic [7:0] cnt;
      logic [7:0] rdata;
      logic irq;
   } dbm_state_s;

   dbm_state_s st;
   dbm_state_s next_st;
   dbm_acc_if acc_bus ();

   localparam logic [7:0] RUN_LAST = 8'(COMPUTE_BANK_CYCLES - 1);

   dbm_shifter u_shift
   (
      .acc(acc_bus)
   );

   logic in_acc;
   logic [7:0] data_ctl;
   assign in_acc = I_ADDR >= DBM_ADDR_ACC0 &&
                   I_ADDR < DBM_ADDR_ACC0 + 8'(DBM_ACC_BYTES);
   assign data_ctl = st.ctl[st.bank];
   assign acc_bus.byte_sel = 3'(I_ADDR - DBM_ADDR_ACC0);
   assign acc_bus.wdata = I_WDATA;
   assign acc_bus.in_shift = data_ctl[DBM_CTL_IN_LSB +: 3];
   assign acc_bus.out_shift = data_ctl[DBM_CTL_OUT_LSB +: 3];
   assign acc_bus.fill = data_ctl[DBM_CTL_FILL];
   assign acc_bus.acc_in = st.acc[st.bank];

   //------------------------------------------------------------
   // bank sequencing and register access
   //------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.irq = 1'b0;
      // calculation runs for a fixed count
      if (st.compute_bank == DBM_COMPUTE_BANK_BUSY)
      begin
         next_st.cnt = st.cnt + 8'h00_01;
         if (st.cnt == RUN_LAST)
         begin
            next_st.irq = st.ctl[~st.bank][DBM_CTL_IE];
            if (st.data_ready)
            begin
               // queued set takes over, result moves to data side
               next_st.bank = ~st.bank;
               next_st.data_ready = 1'b0;
               next_st.data_full = 1'b1;
               next_st.cnt = 8'h00_00;
            end
            else if (!st.data_full)
            begin
               next_st.bank = ~st.bank;
               next_st.data_full = 1'b1;
               next_st.compute_bank = DBM_COMPUTE_BANK_EMPTY;
            end
            else
               next_st.compute_bank = DBM_COMPUTE_BANK_DONE;
         end
      end
      // processor writes
      if (I_WR)
      begin
         if (I_ADDR == DBM_ADDR_CONTROL)
         begin
            // control lands in the data bank of the settled state
            next_st.ctl[next_st.bank] = I_WDATA;
            if (next_st.compute_bank == DBM_COMPUTE_BANK_BUSY)
            begin
               next_st.data_ready = 1'b1;
               next_st.data_full = 1'b0;
            end
            else
            begin
               // a finished result moves to the data side on the swap
               next_st.data_full = next_st.compute_bank == DBM_COMPUTE_BANK_DONE;
               next_st.bank = ~next_st.bank;
               next_st.compute_bank = DBM_COMPUTE_BANK_BUSY;
               next_st.cnt = 8'h00_00;
            end
         end
         else if (in_acc)
            next_st.acc[st.bank] = acc_bus.acc_out;
         else if (I_ADDR == DBM_ADDR_STATUS && I_WDATA == DBM_SWAP_CMD &&
                  st.compute_bank == DBM_COMPUTE_BANK_DONE && !st.data_ready)
         begin
            next_st.bank = ~st.bank;
            next_st.data_full = 1'b1;
            next_st.compute_bank = DBM_COMPUTE_BANK_EMPTY;
         end
      end
      // both empty returns data role to bank 0; a held result keeps it
      if (next_st.compute_bank == DBM_COMPUTE_BANK_EMPTY && !next_st.data_ready &&
          !next_st.data_full)
         next_st.bank = 1'b0;
      // read data
      next_st.rdata = 8'h00_00;
      if (I_RD)
      begin
         if (I_ADDR == DBM_ADDR_CONTROL)
            next_st.rdata = data_ctl;
         else if (in_acc)
            next_st.rdata = acc_bus.rdata;
         else if (I_ADDR == DBM_ADDR_STATUS)
         begin
            next_st.rdata[DBM_STAT_BANK] = st.bank;
            next_st.rdata[DBM_STAT_COMPUTE_BANK_LSB +: 2] = st.compute_bank;
         end
      end
   end

   // state register, reset leaves the accumulators alone and accumulator writes still land during reset
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
      begin
         st.ctl <= {2{DBM_CONTROL_RESET}};
         st.bank <= 1'b0;
         st.data_ready <= 1'b0;
         st.data_full <= 1'b0;
         st.compute_bank <= DBM_COMPUTE_BANK_EMPTY;
         st.cnt <= 8'h00_00;
         st.rdata <= 8'h00_00;
         st.irq <= 1'b0;
         st.acc <= next_st.acc;
      end
      else
         st <= next_st;
   end

   assign O_RDATA = st.rdata;
   assign O_IRQ = st.irq;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   a_compute_bank_code_valid: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N) st.compute_bank != 2'b01)
      else $error("invalid compute state");
   a_empty_bank_zero: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      (st.compute_bank == DBM_COMPUTE_BANK_EMPTY && !st.data_ready && !st.data_full)
      |-> !st.bank)
      else $error("empty banks not on bank 0");
   a_start_runs: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      (I_WR && I_ADDR == DBM_ADDR_CONTROL && st.compute_bank == DBM_COMPUTE_BANK_EMPTY)
      |=> st.compute_bank == DBM_COMPUTE_BANK_BUSY && !st.data_ready)
      else $error("start did not run");
   a_queue_ready: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      (I_WR && I_ADDR == DBM_ADDR_CONTROL && st.compute_bank == DBM_COMPUTE_BANK_BUSY
       && st.cnt != RUN_LAST) |=> st.data_ready)
      else $error("busy start not queued");
   a_irq_only_done: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      O_IRQ |-> $past(st.compute_bank) == DBM_COMPUTE_BANK_BUSY && $past(st.cnt) == RUN_LAST)
      else $error("irq without completion");
   a_swap_cmd: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      (I_WR && I_ADDR == DBM_ADDR_STATUS && I_WDATA == DBM_SWAP_CMD &&
       st.compute_bank == DBM_COMPUTE_BANK_DONE && !st.data_ready)
      |=> st.compute_bank == DBM_COMPUTE_BANK_EMPTY)
      else $error("swap command ignored");
   a_status_read: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      (I_RD && I_ADDR == DBM_ADDR_STATUS)
      |=> O_RDATA == {3'b000, $past(st.bank), $past(st.compute_bank), 2'b00})
      else $error("status read mismatch");
   a_done_swaps: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      (st.compute_bank == DBM_COMPUTE_BANK_BUSY && st.cnt == RUN_LAST && !I_WR &&
       (st.data_ready || !st.data_full))
      |=> st.bank != $past(st.bank))
      else $error("finish did not swap");
   a_done_holds: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      (st.compute_bank == DBM_COMPUTE_BANK_BUSY && st.cnt == RUN_LAST && !I_WR &&
       st.data_full && !st.data_ready)
      |=> st.compute_bank == DBM_COMPUTE_BANK_DONE && st.bank == $past(st.bank))
      else $error("held result not kept done");
   a_irq_enabled: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      (st.compute_bank == DBM_COMPUTE_BANK_BUSY && st.cnt == RUN_LAST &&
       st.ctl[~st.bank][DBM_CTL_IE]) |=> O_IRQ)
      else $error("enabled completion without irq");
   a_busy_bound: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      st.compute_bank == DBM_COMPUTE_BANK_BUSY |-> st.cnt <= RUN_LAST)
      else $error("run count past its end");
   a_start_control: assert property (@(posedge I_CLOCK)
      disable iff (!I_RST_N)
      (I_WR && I_ADDR == DBM_ADDR_CONTROL && st.compute_bank == DBM_COMPUTE_BANK_EMPTY)
      |=> st.ctl[~st.bank] == $past(I_WDATA))
      else $error("started set lost its control");
endmodule // dbm_mac_engine

/* logic/dbm_pkg.sv */
package dbm_pkg;
   //------------------------------------------------------------
   // register map
   //------------------------------------------------------------
   localparam logic [7:0] DBM_ADDR_CONTROL = 8'h00_E7;
   localparam logic [7:0] DBM_ADDR_ACC0 = 8'h00_E8;
   localparam logic [7:0] DBM_ADDR_STATUS = 8'h00_ED;
   localparam logic [7:0] DBM_CONTROL_RESET = 8'h00_00;
   localparam logic [7:0] DBM_SWAP_CMD = 8'h00_80;
   localparam int DBM_ACC_BYTES = 5;
   localparam int DBM_ACC_W = 40;
   // control fields
   localparam int DBM_CTL_IE = 7;
   localparam int DBM_CTL_FILL = 6;
   localparam int DBM_CTL_OUT_LSB = 3;
   localparam int DBM_CTL_IN_LSB = 0;
   // status fields
   localparam int DBM_STAT_BANK = 4;
   localparam int DBM_STAT_COMPUTE_BANK_LSB = 2;
   // default length of one calculation in cycles
   localparam int DBM_COMPUTE_BANK_CYCLES = 8;

   // compute bank state codes
   typedef enum logic [1:0]
   {
      DBM_COMPUTE_BANK_EMPTY = 2'b00,
      DBM_COMPUTE_BANK_BUSY = 2'b10,
      DBM_COMPUTE_BANK_DONE = 2'b11
   } dbm_compute_bank_e;
endpackage

/* logic/dbm_acc_if.sv */
`timescale 1ns/1ps
// accumulator byte port between sequencer and shifter
interface dbm_acc_if;
   logic [2:0] byte_sel;
   logic [7:0] wdata;
   logic [2:0] in_shift;
   logic [2:0] out_shift;
   logic fill;
   logic [39:0] acc_in;
   logic [39:0] acc_out;
   logic [7:0] rdata;
   modport core (output byte_sel, wdata, in_shift, out_shift, fill,
                 acc_in, input acc_out, rdata);
   modport shift (input byte_sel, wdata, in_shift, out_shift, fill,
                  acc_in, output acc_out, rdata);
endinterface

/* logic/dbm_shifter.sv */
`timescale 1ns/1ps
module dbm_shifter
   import dbm_pkg::*;
(
   dbm_acc_if.shift acc
);
   //------------------------------------------------------------
   // write and read shifting
   //------------------------------------------------------------
   logic [39:0] merged;
   logic [39:0] shifted_in;
   logic [39:0] shifted_out;
   logic [39:0] fill_mask;

   // byte merge then left shift with fill bit
   always_comb
   begin
      merged = acc.acc_in;
      merged[acc.byte_sel*8 +: 8] = acc.wdata;
      fill_mask = ~({40{1'b1}} << acc.in_shift);
      shifted_in = (merged << acc.in_shift) |
                   (acc.fill ? fill_mask : 40'h00_0000_0000);
      acc.acc_out = shifted_in;
      shifted_out = 40'($signed(acc.acc_in) >>> acc.out_shift);
      acc.rdata = shifted_out[acc.byte_sel*8 +: 8];
   end
endmodule // dbm_shifter

/* verification/dbm_host_model.sv */
`timescale 1ns/1ps
`define DBM_CMP(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("unexpected %0t got %h exp %h", $time, got, exp); \
      end \
   end
module dbm_host_model
   import dbm_pkg::*;
(
   // clock and read data
   input wire logic i_clock,
   input wire logic [7:0] i_rdata,
   // bus requests
   output logic [7:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_wdata
);
   logic [7:0] exp_q[$];
   logic [7:0] e;
   logic rd_q = 1'b0;
   int fail_count = 0;
   int num_checks = 0;
   initial {o_addr, o_wr, o_rd, o_wdata} = '0;
   // one access over one rising edge; a read notes its expectation
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(negedge i_clock);
      {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
      if (!w)
         exp_q.push_back(d);
      @(negedge i_clock);
      {o_wr, o_rd} = 2'b00;
   endtask
   task automatic chk(input logic [7:0] got, exp);
      `DBM_CMP(got, exp)
   endtask
   // read data stands in the cycle after the taking edge
   always @(posedge i_clock)
      rd_q <= o_rd;
   always @(negedge i_clock)
      if (rd_q)
      begin
         e = exp_q.pop_front();
         `DBM_CMP(i_rdata, e)
      end
endmodule // dbm_host_model

/* verification/test_dual_bank_multiply_accumulator.sv */
`timescale 1ns/1ps
module test_dual_bank_multiply_accumulator;
   import dbm_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, irq;
   logic [39:0] acc;
   logic [31:0] seed = 32'hf2a4_9319;
   int irq_count = 0;
   always #50 clk = !clk;
   dbm_mac_engine #(.COMPUTE_BANK_CYCLES(8)) dut (.I_CLOCK(clk), .I_RST_N(rst_n),
      .I_ADDR(addr), .I_WR(wr), .I_RD(rd), .I_WDATA(wdata),
      .O_RDATA(rdata), .O_IRQ(irq));
   // host loads control before each start and reads after the swap
   dbm_host_model host (.i_clock(clk), .i_rdata(rdata), .o_addr(addr),
      .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
   always @(negedge clk)
      if (irq === 1'b1)
         irq_count++;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // load shifts, then write and read all five accumulator bytes
   task automatic shift_case(input logic [7:0] ctl);
      logic [39:0] r;
      int n;
      n = ctl[2:0];
      host.acc(1, DBM_ADDR_CONTROL, ctl);
      repeat (14) @(negedge clk);
      host.acc(0, DBM_ADDR_CONTROL, ctl);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_10);
      for (int k = 0; k < 5; k++)
      begin
         seed = xs(seed);
         acc[8*k +: 8] = seed[7:0];
         acc = (acc << n) | ({40{ctl[6]}} >> (40 - n));
         host.acc(1, DBM_ADDR_ACC0 + 8'(k), seed[7:0]);
      end
      r = $signed(acc) >>> ctl[5:3];
      for (int k = 0; k < 5; k++)
         host.acc(0, DBM_ADDR_ACC0 + 8'(k), r[8*k +: 8]);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", host.num_checks,
         host.fail_count);
      if (host.fail_count == 0 && host.num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge clk);
      host.fail_count++;
      tally_and_finish();
   end
   initial
   begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      host.acc(0, DBM_ADDR_CONTROL, 8'h00_00);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_00);
      host.acc(0, 8'h00_E6, 8'h00_00);
      $display("test reset done");
      host.acc(1, DBM_ADDR_CONTROL, 8'h00_80);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_18);
      repeat (12) @(negedge clk);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_00);
      host.chk(8'(irq_count), 8'h00_01);
      $display("test single run done");
      host.acc(1, DBM_ADDR_CONTROL, 8'h00_80);
      host.acc(1, DBM_ADDR_CONTROL, 8'h00_80);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_18);
      repeat (8) @(negedge clk);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_08);
      repeat (12) @(negedge clk);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_0C);
      host.chk(8'(irq_count), 8'h00_03);
      host.acc(1, DBM_ADDR_STATUS, 8'h00_40);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_0C);
      host.acc(1, DBM_ADDR_STATUS, DBM_SWAP_CMD);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_10);
      // a held result stays done, then a start from done
      host.acc(1, DBM_ADDR_CONTROL, 8'h00_00);
      host.acc(1, DBM_ADDR_CONTROL, 8'h00_00);
      repeat (20) @(negedge clk);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_1C);
      host.acc(1, DBM_ADDR_CONTROL, 8'h00_00);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_08);
      repeat (12) @(negedge clk);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_0C);
      host.acc(1, DBM_ADDR_STATUS, DBM_SWAP_CMD);
      host.acc(0, DBM_ADDR_STATUS, 8'h00_10);
      $display("test deferred run done");
      for (int i = 0; i < 8; i++)
         shift_case({1'b0, i[0], 3'(7 - i), 3'(i)});
      host.chk(8'(irq_count), 8'h00_03);
      $display("test shifts done");
      tally_and_finish();
   end
endmodule // test_dual_bank_multiply_accumulator
